// [inc/pwm_gen_pkg.sv]
// Constants, types and helpers shared by the 10-bit PWM generator files
// Function
// RL1 - Two-bit mode: one-shot, auto-enable one-shot, repeat
// RL2 - Counter clock is system clock divided 1..128
// RL3 - Counter counts up, inverts output at match
// RL4 - One-shot restart edge clears counter, restarts generator
// RL5 - One-shot overflow sets flag, stops, clears enable
// RL6 - Auto-enable restart edge sets enable unless emergency
// RL7 - Software clears emergency flag before expecting restart
// RL8 - Repeat mode wraps counter at 3FF and restarts
// RL9 - Restart edge starts cycle now or after delay
// RL10 - Each stop pin selects shot or emergency stop
// RL11 - Shot stop holds idle level, next cycle uses B
// RL12 - Emergency stop pin edge stops the generator
// RL13 - Zero filter length bypasses filter, short edges rejected
// RL14 - Filter timer restarts at every new cycle
// RL15 - Duty values split as bits 9:8 and 7:0
// RL16 - Counter readable only, split high and low
// RL17 - Clock code 000 is /128, 111 is /1
// RL18 - Enable write starts; emergency clears enable at once
// RL19 - Four sticky event flags, cleared by writing zero
// RL20 - Disabled output sits at polarity level
// RL21 - Pins synchronised and falling edges detected first
package pwm_gen_pkg;

  // Register indices; byte address is four times the index
  localparam logic [12:0] IDX_IRQ_EN = 13'h103E;
  localparam logic [12:0] IDX_FLAGS = 13'h103F;
  localparam logic [12:0] IDX_DELAY = 13'h1066;
  localparam logic [12:0] IDX_FILTER = 13'h1067;
  localparam logic [12:0] IDX_CTL_LO = 13'h1078;
  localparam logic [12:0] IDX_CTL_HI = 13'h1079;
  localparam logic [12:0] IDX_DUTY_A_LO = 13'h107A;
  localparam logic [12:0] IDX_DUTY_A_HI = 13'h107B;
  localparam logic [12:0] IDX_DUTY_B_LO = 13'h107C;
  localparam logic [12:0] IDX_DUTY_B_HI = 13'h107D;
  localparam logic [12:0] IDX_COUNT_LO = 13'h107E;
  localparam logic [12:0] IDX_COUNT_HI = 13'h107F;

  // Reset values
  localparam logic [7:0] RST_FILTER = 8'h0F;
  localparam logic [9:0] RST_DUTY_A = 10'h3FF;
  localparam logic [9:0] RST_DUTY_B = 10'h000;

  // Control low fields
  localparam int POS_POL = 4;
  localparam int POS_MODE = 2;
  localparam int POS_TRG_EN = 1;
  localparam int POS_TRG_DLY = 0;
  // Control high fields
  localparam int POS_CNT_CLR = 1;
  localparam int POS_ENABLE = 0;
  // Flag and enable bit positions
  localparam int FLG_OVF = 3;
  localparam int FLG_EMG = 2;
  localparam int FLG_SHOT = 1;
  localparam int FLG_TRG = 0;

  // Mode and stop select codes, counter end values
  localparam logic [1:0] MODE_AUTO = 2'h1;
  localparam logic [1:0] STOP_SHOT = 2'h1;
  localparam logic [1:0] STOP_EMG = 2'h2;
  localparam logic [9:0] CNT_TOP = 10'h3FF;
  localparam logic [9:0] CNT_ZERO = 10'h000;

  // Engine states
  typedef enum logic [1:0] {ST_IDLE, ST_DELAY, ST_RUN} run_state_t;

  // Prescaler tick mask: code 0 waits 128 clocks, code 7 every clock
  function automatic logic [6:0] div_mask(input logic [2:0] sel);
    return 7'h7F >> sel;
  endfunction

endpackage

// [inc/edge_if.sv]
// Carrier between the pin conditioner and the generator core
`timescale 1ns/1ns
`default_nettype none
interface edge_if;
  logic restart_valid; // Filtered restart edge, one clock
  logic [2:0] stop_fall; // Stop pin falling edges, one clock each
  logic [7:0] filter_len; // Filter length in system clocks
  logic cycle_start; // New cycle began, clears filter timer
  modport cond (input filter_len, input cycle_start,
                output restart_valid, output stop_fall);
  modport core (output filter_len, output cycle_start,
                input restart_valid, input stop_fall);
endinterface
`default_nettype wire

// [rtl/pin_conditioner.sv]
// Synchroniser and edge detector for the external pins, noise filter for the restart pin
`timescale 1ns/1ns
`default_nettype none
module pin_conditioner
  import pwm_gen_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic restart_edge_input_i,
  input wire logic [2:0] stop_input_i,
  edge_if.cond link
);

  // Whole state of this module
  typedef struct packed {
    logic trg_s1; // First sync stage, read only by second
    logic trg_s2;
    logic trg_prev;
    logic [2:0] stp_s1;
    logic [2:0] stp_s2;
    logic [2:0] stp_prev;
    logic [2:0] stp_fall;
    logic armed; // Low level being timed
    logic [7:0] fcnt;
    logic valid;
  } cond_state_t;

  cond_state_t q;
  cond_state_t next_q;
  logic trg_fall;

  // Falling edge seen on synchronised copies only
  assign trg_fall = q.trg_prev & ~q.trg_s2; // see RL21

  // Next state
  always_comb
  begin
    next_q = q;
    next_q.trg_s1 = restart_edge_input_i; // see RL21
    next_q.trg_s2 = q.trg_s1;
    next_q.trg_prev = q.trg_s2;
    next_q.stp_s1 = stop_input_i;
    next_q.stp_s2 = q.stp_s1;
    next_q.stp_prev = q.stp_s2;
    next_q.stp_fall = q.stp_prev & ~q.stp_s2; // see RL21
    next_q.valid = 1'b0;
    // New cycle restarts the judging timer
    if (link.cycle_start)
    begin
      next_q.armed = 1'b0; // see RL14
      next_q.fcnt = 8'h00;
    end
    if (link.filter_len == 8'h00)
    begin
      // Filter bypassed, every edge counts
      next_q.valid = trg_fall; // see RL13
      next_q.armed = 1'b0;
    end
    else if (trg_fall)
    begin
      // Start timing the low level
      next_q.armed = 1'b1;
      next_q.fcnt = 8'h00;
    end
    else if (q.armed && !link.cycle_start)
    begin
      // A new cycle disarms the timer, so a late count cannot fire
      if (q.trg_s2)
        next_q.armed = 1'b0; // Pulse too short, rejected; see RL13
      else if (q.fcnt + 8'h01 == link.filter_len)
      begin
        next_q.valid = 1'b1;
        next_q.armed = 1'b0;
      end
      else
        next_q.fcnt = q.fcnt + 8'h01;
    end
  end

  // State register; pins idle high so sync stages reset high
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      q <= '0;
      q.trg_s1 <= 1'b1;
      q.trg_s2 <= 1'b1;
      q.trg_prev <= 1'b1;
      q.stp_s1 <= 3'h7;
      q.stp_s2 <= 3'h7;
      q.stp_prev <= 3'h7;
    end
    else
      q <= next_q;
  end

  assign link.restart_valid = q.valid;
  assign link.stop_fall = q.stp_fall;

  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  a_filter_bypass: assert property ( // see RL13
    (link.filter_len == 8'h00) && trg_fall |=> q.valid)
    else $error("bypassed filter dropped an edge");

  a_filter_clear: assert property ( // see RL14
    link.cycle_start && !trg_fall && (link.filter_len != 8'h00)
    |=> !q.armed && !q.valid)
    else $error("filter timer not cleared at new cycle");

endmodule
`default_nettype wire

// [rtl/ten_bit_pwm.sv]
// Ten-bit triggered PWM generator with Avalon-MM register slave
//
// The Avalon-MM interface to the registers was decided locally.
`timescale 1ns/1ns
`default_nettype none
module ten_bit_pwm
  import pwm_gen_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic [14:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [3:0] avs_byteenable_i,
  input wire logic [31:0] avs_writedata_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic restart_edge_input_i,
  input wire logic stop_input_0_i,
  input wire logic stop_input_1_i,
  input wire logic stop_input_2_i,
  output logic pulse_output_o
);

  // Whole state of the generator
  typedef struct packed {
    run_state_t st;
    logic [9:0] cnt; // Count value
    logic [9:0] duty_a; // Match value in use
    logic [9:0] duty_b; // Value taken after a shot stop
    logic [6:0] pre; // Free running prescaler
    logic [7:0] dly_cnt; // Remaining restart delay ticks
    logic [7:0] dly; // Restart delay value
    logic [7:0] nfil; // Glitch filter length
    logic [7:0] ctl_lo;
    logic [7:0] ctl_hi;
    logic [3:0] irq_en; // Per-event enables, stored only
    logic [3:0] flags; // Sticky event flags
    logic phase; // High before match, low after
    logic shot_hold; // Output held until cycle end
    logic out;
    logic ack; // Bus answer phase
    logic [7:0] rdata;
    logic nc; // New cycle pulse
  } gen_state_t;

  gen_state_t q;
  gen_state_t next_q;
  edge_if link ();

  // Decoded bus and control helpers
  logic [12:0] idx;
  logic wr_fire;
  logic tick;
  logic end_tick;
  logic repeat_mode;
  logic emg_ev;
  logic shot_ev;
  logic restart_ev;
  logic auto_ok;
  logic start_sw;
  logic [2:0] stop_fall;
  logic [7:0] rd;

  // Pin conditioning lives in its own module
  pin_conditioner u_cond (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .restart_edge_input_i(restart_edge_input_i),
    .stop_input_i({stop_input_2_i, stop_input_1_i, stop_input_0_i}),
    .link(link.cond)
  );

  assign link.filter_len = q.nfil;
  assign link.cycle_start = q.nc;
  assign stop_fall = link.stop_fall;

  // Misaligned byte addresses fall into the unmapped space
  assign idx = (avs_address_i[1:0] == 2'h0) ? avs_address_i[14:2]
                                            : 13'h0000;
  // Write lands at the edge where waitrequest is low
  assign wr_fire = avs_write_i & q.ack & avs_byteenable_i[0];
  // First cycle of a request waits, second answers
  assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~q.ack;
  assign avs_readdata_o = {24'h000000, q.rdata};
  assign pulse_output_o = q.out;

  // Prescaler tick from the clock select code
  assign tick = (q.pre & div_mask(q.ctl_lo[7:5])) ==
                div_mask(q.ctl_lo[7:5]); // see RL2 see RL17
  assign end_tick = (q.st == ST_RUN) && tick && (q.cnt == CNT_TOP);
  assign repeat_mode = q.ctl_lo[POS_MODE + 1]; // see RL1

  // Stop pin events by their select fields
  always_comb
  begin
    emg_ev = 1'b0;
    shot_ev = 1'b0;
    for (int i = 0; i < 3; i++)
    begin
      if (stop_fall[i] && q.ctl_hi[2 * i + 2 +: 2] == STOP_EMG)
        emg_ev = 1'b1; // see RL10
      if (stop_fall[i] && q.ctl_hi[2 * i + 2 +: 2] == STOP_SHOT)
        shot_ev = 1'b1; // see RL10
    end
  end

  // Restart edge only counts with the restart function on
  assign restart_ev = link.restart_valid & q.ctl_lo[POS_TRG_EN];
  // Auto-enable is barred while the emergency flag stands
  assign auto_ok = (q.ctl_lo[POS_MODE +: 2] == MODE_AUTO) &&
                   !q.flags[FLG_EMG]; // see RL6 see RL7
  assign start_sw = wr_fire && (idx == IDX_CTL_HI) &&
                    avs_writedata_i[POS_ENABLE];

  // Read multiplexer, unmapped reads give zero
  always_comb
  begin
    rd = 8'h00;
    case (idx)
      IDX_IRQ_EN: rd = {4'h0, q.irq_en};
      IDX_FLAGS: rd = {4'h0, q.flags};
      IDX_DELAY: rd = q.dly;
      IDX_FILTER: rd = q.nfil;
      IDX_CTL_LO: rd = q.ctl_lo;
      IDX_CTL_HI: rd = q.ctl_hi;
      IDX_DUTY_A_LO: rd = q.duty_a[7:0]; // see RL15
      IDX_DUTY_A_HI: rd = {6'h00, q.duty_a[9:8]};
      IDX_DUTY_B_LO: rd = q.duty_b[7:0];
      IDX_DUTY_B_HI: rd = {6'h00, q.duty_b[9:8]};
      IDX_COUNT_LO: rd = q.cnt[7:0]; // see RL16
      IDX_COUNT_HI: rd = {6'h00, q.cnt[9:8]};
      default: rd = 8'h00;
    endcase
  end

  // Next state: bus writes first, hardware events after so they win, except a restart edge, dropped in the cycle of an enable write
  always_comb
  begin
    next_q = q;
    next_q.nc = 1'b0;
    next_q.pre = q.pre + 7'h01;
    next_q.ack = (avs_read_i | avs_write_i) & ~q.ack;
    if (avs_read_i && !q.ack)
      next_q.rdata = rd;

    // Register writes; count registers ignore writes
    if (wr_fire)
    begin
      case (idx)
        IDX_IRQ_EN: next_q.irq_en = avs_writedata_i[3:0];
        IDX_FLAGS: next_q.flags = q.flags & avs_writedata_i[3:0];
        IDX_DELAY: next_q.dly = avs_writedata_i[7:0];
        IDX_FILTER: next_q.nfil = avs_writedata_i[7:0];
        IDX_CTL_LO: next_q.ctl_lo = avs_writedata_i[7:0];
        IDX_CTL_HI: next_q.ctl_hi = avs_writedata_i[7:0];
        IDX_DUTY_A_LO: next_q.duty_a[7:0] = avs_writedata_i[7:0];
        IDX_DUTY_A_HI: next_q.duty_a[9:8] = avs_writedata_i[1:0];
        IDX_DUTY_B_LO: next_q.duty_b[7:0] = avs_writedata_i[7:0];
        IDX_DUTY_B_HI: next_q.duty_b[9:8] = avs_writedata_i[1:0];
        default: next_q.ctl_hi = next_q.ctl_hi;
      endcase
      // Counter clear bit acts once and reads back zero
      if (idx == IDX_CTL_HI && avs_writedata_i[POS_CNT_CLR])
        next_q.cnt = CNT_ZERO;
    end
    next_q.ctl_hi[POS_CNT_CLR] = 1'b0;

    // Writing one to enable clears the count and starts
    if (start_sw)
    begin
      next_q.st = ST_RUN; // see RL18
      next_q.cnt = CNT_ZERO;
      next_q.phase = 1'b1;
      next_q.shot_hold = 1'b0;
      next_q.nc = 1'b1;
    end
    else
    begin
      // Engine step on the prescaled clock
      case (q.st)
        ST_RUN:
        begin
          if (tick)
          begin
            // Match inverts the output
            if (q.cnt == q.duty_a)
              next_q.phase = ~q.phase; // see RL3
            if (q.cnt == CNT_TOP)
            begin
              // Cycle end takes B after a shot stop
              if (q.shot_hold)
              begin
                next_q.duty_a = q.duty_b; // see RL11
                next_q.shot_hold = 1'b0;
              end
              if (repeat_mode)
              begin
                next_q.cnt = CNT_ZERO; // see RL8
                next_q.phase = 1'b1;
                next_q.nc = 1'b1;
              end
              else
              begin
                next_q.flags[FLG_OVF] = 1'b1; // see RL5
                next_q.ctl_hi[POS_ENABLE] = 1'b0;
                next_q.st = ST_IDLE;
                next_q.phase = 1'b0;
              end
            end
            else
              next_q.cnt = q.cnt + 10'h001; // see RL3
          end
        end
        ST_DELAY:
        begin
          // Delay counted in prescaled ticks, output idle
          if (tick)
          begin
            if (q.dly_cnt == 8'h00)
            begin
              next_q.st = ST_RUN; // see RL9
              next_q.phase = 1'b1;
              next_q.nc = 1'b1;
            end
            else
              next_q.dly_cnt = q.dly_cnt - 8'h01;
          end
        end
        ST_IDLE:
          next_q.phase = 1'b0;
        default:
          next_q.st = ST_IDLE;
      endcase

      // Restart edge: clear and begin, now or after delay
      if (restart_ev && (q.st != ST_IDLE || auto_ok))
      begin
        next_q.flags[FLG_TRG] = 1'b1; // see RL19
        if (q.st == ST_IDLE)
          next_q.ctl_hi[POS_ENABLE] = 1'b1; // see RL6
        next_q.cnt = CNT_ZERO; // see RL4 see RL9
        next_q.nc = 1'b1;
        if (q.ctl_lo[POS_TRG_DLY])
        begin
          next_q.st = ST_DELAY; // see RL9
          next_q.dly_cnt = q.dly;
          next_q.phase = 1'b0;
        end
        else
        begin
          next_q.st = ST_RUN; // see RL4
          next_q.phase = 1'b1;
        end
      end
    end

    // Shot stop holds the output for the rest of the cycle
    if (shot_ev && next_q.st != ST_IDLE)
    begin
      next_q.shot_hold = 1'b1; // see RL11
      next_q.flags[FLG_SHOT] = 1'b1; // see RL19
    end

    // Emergency stop beats everything, enable drops at once
    if (emg_ev)
    begin
      next_q.ctl_hi[POS_ENABLE] = 1'b0; // see RL12 see RL18
      next_q.flags[FLG_EMG] = 1'b1; // see RL19
    end

    // Disabled generator parks in idle
    if (!next_q.ctl_hi[POS_ENABLE])
    begin
      next_q.st = ST_IDLE;
      next_q.phase = 1'b0;
      next_q.shot_hold = 1'b0;
    end

    // Output from flop: polarity level unless in the live phase
    next_q.out = next_q.ctl_lo[POS_POL] ^
                 (next_q.phase && !next_q.shot_hold &&
                  next_q.st == ST_RUN); // see RL20 see RL11
  end

  // State register
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      q <= '0;
      q.st <= ST_IDLE;
      q.nfil <= RST_FILTER;
      q.duty_a <= RST_DUTY_A;
      q.duty_b <= RST_DUTY_B;
    end
    else
      q <= next_q;
  end

  // Checks next to the logic
  logic quiet; // No event can disturb the engine this cycle
  assign quiet = !restart_ev && !emg_ev && !start_sw && !shot_ev &&
                 !wr_fire;

  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  sequence s_shot_taken;
    shot_ev && (q.st == ST_RUN) && !emg_ev ##1 q.shot_hold;
  endsequence

  sequence s_cycle_end_held;
    q.shot_hold && end_tick && quiet;
  endsequence

  a_idle_level: assert property ( // see RL20
    (q.st == ST_IDLE) |-> (pulse_output_o == q.ctl_lo[POS_POL]))
    else $error("idle output not at polarity level");

  a_count_step: assert property ( // see RL3
    (q.st == ST_RUN) && tick && (q.cnt != CNT_TOP) && quiet
    |=> q.cnt == $past(q.cnt) + 10'h001)
    else $error("counter did not step by one");

  a_match_invert: assert property ( // see RL3
    (q.st == ST_RUN) && tick && (q.cnt == q.duty_a) &&
    (q.cnt != CNT_TOP) && quiet |=> q.phase != $past(q.phase))
    else $error("match did not invert output");

  a_oneshot_stop: assert property ( // see RL5
    end_tick && !repeat_mode && quiet
    |=> !q.ctl_hi[POS_ENABLE] && q.flags[FLG_OVF] &&
        (q.st == ST_IDLE))
    else $error("one-shot overflow did not stop");

  a_repeat_wrap: assert property ( // see RL8
    end_tick && repeat_mode && quiet
    |=> (q.cnt == CNT_ZERO) && (q.st == ST_RUN) && q.nc)
    else $error("repeat mode did not wrap");

  a_emergency_stop: assert property ( // see RL12
    emg_ev |=> !q.ctl_hi[POS_ENABLE] && (q.st == ST_IDLE) &&
               q.flags[FLG_EMG])
    else $error("emergency stop did not halt");

  a_auto_enable: assert property ( // see RL6
    restart_ev && auto_ok && (q.st == ST_IDLE) && !emg_ev &&
    !wr_fire |=> q.ctl_hi[POS_ENABLE] && (q.st != ST_IDLE))
    else $error("auto-enable did not start");

  a_restart_delay: assert property ( // see RL9
    restart_ev && (q.st == ST_RUN) && q.ctl_lo[POS_TRG_DLY] &&
    !emg_ev && !start_sw && !wr_fire
    |=> (q.st == ST_DELAY) && (q.cnt == CNT_ZERO))
    else $error("delayed restart not entered");

  a_flag_sticky: assert property ( // see RL19
    q.flags[FLG_TRG] && !(wr_fire && idx == IDX_FLAGS)
    |=> q.flags[FLG_TRG])
    else $error("event flag cleared without write");

  a_shot_hold: assert property ( // see RL11
    s_shot_taken |-> pulse_output_o == q.ctl_lo[POS_POL])
    else $error("shot stop did not hold output");

  a_shot_reload: assert property ( // see RL11
    s_cycle_end_held |=> q.duty_a == $past(q.duty_b))
    else $error("shot stop did not load B value");

  a_bus_answer: assert property (
    (avs_read_i || avs_write_i) && !q.ack |=> !avs_waitrequest_o)
    else $error("bus answer took more than one wait");

endmodule
`default_nettype wire

// [verif/pin_source.sv]
// Model of the restart and stop pin drivers
`timescale 1ns/1ns
`default_nettype none
module pin_source
(
  input wire logic ref_clk_i,
  output logic restart_o,
  output logic [2:0] stop_o
);
  // Lines idle high, as if pulled up
  initial
  begin
    restart_o = 1'b1;
    stop_o = 3'h7;
  end
  // Low pulse of len clocks; pin 3 is restart, 0..2 are stops
  task automatic pulse(input int pin, input int len);
    if (pin == 3)
      restart_o <= 1'b0;
    else
      stop_o[pin] <= 1'b0;
    repeat (len) @(posedge ref_clk_i);
    restart_o <= 1'b1;
    stop_o <= 3'h7;
  endtask
endmodule
`default_nettype wire

// [verif/ten_bit_pwm_tb.sv]
// Self-checking bench for the ten-bit PWM generator
`timescale 1ns/1ns
`default_nettype none
module ten_bit_pwm_tb
  import pwm_gen_pkg::*;
;
  logic ref_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [14:0] avs_address_i = 15'h0000;
  logic avs_read_i = 1'b0;
  logic avs_write_i = 1'b0;
  logic [3:0] avs_byteenable_i = 4'hF;
  logic [31:0] avs_writedata_i = 32'h00000000;
  logic [31:0] avs_readdata_o;
  logic avs_waitrequest_o;
  logic pulse_output_o;
  logic restart_in;
  logic [2:0] stop_in;
  int n_mismatch = 0;
  int check_count = 0;
  int cyc = 0;
  logic [31:0] rv; // Last read data
  // 25 MHz clock
  always #20 ref_clk_i = ~ref_clk_i;
  ten_bit_pwm i_ten_bit_pwm (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
    .avs_write_i(avs_write_i), .avs_byteenable_i(avs_byteenable_i),
    .avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o),
    .restart_edge_input_i(restart_in), .stop_input_0_i(stop_in[0]),
    .stop_input_1_i(stop_in[1]), .stop_input_2_i(stop_in[2]),
    .pulse_output_o(pulse_output_o));
  pin_source i_pin_source (.ref_clk_i(ref_clk_i), .restart_o(restart_in),
    .stop_o(stop_in));
  // Verdict and end of run
  task automatic wrap_up;
    $display("checks %0d, mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // Hang guard; run needs about 4800 clocks
  always @(posedge ref_clk_i)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      n_mismatch++;
      $display("unexpected timeout: expected end, seen hang");
      wrap_up();
    end
  end
  // Range compare; an unknown never counts as inside
  task automatic chk(input string what, input logic [31:0] lo,
                     input logic [31:0] hi, input logic [31:0] got);
    check_count++;
    if ((got >= lo && got <= hi) !== 1'b1)
    begin
      n_mismatch++;
      $display("unexpected %s: expected %h..%h, seen %h", what, lo, hi, got);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk_i);
  endtask
  // Avalon transfer held until waitrequest is seen low at a rising
  // edge; values read right after the edge are the pre-edge ones
  task automatic bus(input logic wr, input logic [12:0] idx,
                     input logic [7:0] d);
    avs_address_i <= {idx, 2'b00};
    avs_writedata_i <= {24'h000000, d};
    avs_write_i <= wr;
    avs_read_i <= !wr;
    @(posedge ref_clk_i);
    while (avs_waitrequest_o !== 1'b0)
      @(posedge ref_clk_i);
    rv = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
    @(posedge ref_clk_i);
  endtask
  task automatic wr(input logic [12:0] idx, input logic [7:0] d);
    bus(1'b1, idx, d);
  endtask
  // Read and compare whole word; upper bits must be zero
  task automatic rd(input logic [12:0] idx, input logic [7:0] e,
                    input string what);
    bus(1'b0, idx, 8'h00);
    chk(what, {24'h000000, e}, {24'h000000, e}, rv);
  endtask
  // Output looked at mid-cycle, where it is settled
  task automatic out_is(input logic e);
    @(negedge ref_clk_i);
    chk("pulse_output", {31'h0, e}, {31'h0, e}, {31'h0, pulse_output_o});
    @(posedge ref_clk_i);
  endtask
  // Stop generator, clear sticky flags
  task automatic idle;
    wr(IDX_CTL_HI, 8'h00);
    wr(IDX_FLAGS, 8'h00);
  endtask
  task automatic t_reset;
    rd(IDX_FILTER, 8'h0F, "filter reset");
    rd(IDX_DUTY_A_LO, 8'hFF, "duty a low reset");
    rd(IDX_DUTY_A_HI, 8'h03, "duty a high reset");
    rd(IDX_CTL_LO, 8'h00, "control low reset");
    wr(IDX_COUNT_LO, 8'h55);
    rd(IDX_COUNT_LO, 8'h00, "count low");
    wr(IDX_DUTY_B_HI, 8'h02);
    rd(IDX_DUTY_B_HI, 8'h02, "duty b high");
    rd(13'h1000, 8'h00, "unmapped");
    wr(IDX_IRQ_EN, 8'h0F);
    rd(IDX_IRQ_EN, 8'h0F, "irq enable");
    out_is(1'b0);
    wr(IDX_CTL_LO, 8'h10);
    tick(2);
    out_is(1'b1);
    $display("test reset done");
  endtask
  // Slowest and a fast divider, eight ticks each
  task automatic t_prescale;
    for (int c = 0; c < 8; c += 6)
    begin
      wr(IDX_CTL_LO, {c[2:0], 5'h08});
      wr(IDX_CTL_HI, 8'h01);
      tick(8 * (128 >> c));
      bus(1'b0, IDX_COUNT_LO, 8'h00);
      chk("count after eight ticks", 6, 11, rv);
      // Clear bit with enable low: count zeroed, bit reads back zero
      wr(IDX_CTL_HI, 8'h02);
      rd(IDX_COUNT_LO, 8'h00, "count cleared");
      rd(IDX_CTL_HI, 8'h00, "clear bit self-clears");
      idle();
    end
    $display("test prescale done");
  endtask
  task automatic t_overflow;
    wr(IDX_DUTY_A_HI, 8'h00);
    wr(IDX_DUTY_A_LO, 8'h40);
    wr(IDX_CTL_LO, 8'hE0);
    wr(IDX_CTL_HI, 8'h01);
    tick(20);
    out_is(1'b1);
    tick(60);
    out_is(1'b0);
    tick(1000);
    rd(IDX_FLAGS, 8'h08, "flags after overflow");
    rd(IDX_CTL_HI, 8'h00, "enable after overflow");
    wr(IDX_FLAGS, 8'h00);
    rd(IDX_FLAGS, 8'h00, "flags cleared");
    $display("test overflow done");
  endtask
  task automatic t_restart;
    wr(IDX_FILTER, 8'h00);
    wr(IDX_CTL_LO, 8'hE2);
    wr(IDX_CTL_HI, 8'h01);
    tick(600);
    i_pin_source.pulse(3, 2);
    tick(3);
    bus(1'b0, IDX_COUNT_LO, 8'h00);
    chk("count after restart", 0, 20, rv);
    tick(500);
    rd(IDX_FLAGS, 8'h01, "flags after restart");
    rd(IDX_CTL_HI, 8'h01, "enable after restart");
    idle();
    $display("test restart done");
  endtask
  task automatic t_emergency_auto;
    wr(IDX_CTL_LO, 8'hE8);
    wr(IDX_CTL_HI, 8'h09);
    tick(20);
    out_is(1'b1);
    i_pin_source.pulse(0, 2);
    tick(6);
    out_is(1'b0);
    rd(IDX_CTL_HI, 8'h08, "enable after emergency");
    rd(IDX_FLAGS, 8'h04, "emergency flag");
    // Auto mode with delay; emergency flag still set blocks start
    wr(IDX_DELAY, 8'h20);
    wr(IDX_DUTY_A_LO, 8'h80);
    wr(IDX_CTL_LO, 8'hE7);
    i_pin_source.pulse(3, 2);
    tick(60);
    rd(IDX_CTL_HI, 8'h08, "blocked auto enable");
    wr(IDX_FLAGS, 8'h00);
    i_pin_source.pulse(3, 2);
    tick(15);
    out_is(1'b0);
    tick(40);
    out_is(1'b1);
    rd(IDX_CTL_HI, 8'h09, "auto enable");
    rd(IDX_FLAGS, 8'h01, "restart flag");
    idle();
    $display("test emergency and auto done");
  endtask
  task automatic t_shot;
    wr(IDX_DUTY_A_HI, 8'h03);
    wr(IDX_DUTY_A_LO, 8'h00);
    wr(IDX_DUTY_B_HI, 8'h00);
    wr(IDX_DUTY_B_LO, 8'h10);
    wr(IDX_CTL_LO, 8'hE8);
    wr(IDX_CTL_HI, 8'h11);
    tick(100);
    i_pin_source.pulse(2, 2);
    tick(6);
    out_is(1'b1);
    i_pin_source.pulse(1, 2);
    tick(6);
    out_is(1'b0);
    rd(IDX_FLAGS, 8'h02, "shot flag");
    tick(1000);
    rd(IDX_DUTY_A_LO, 8'h10, "duty a after shot");
    rd(IDX_DUTY_A_HI, 8'h00, "duty a high after shot");
    rd(IDX_CTL_HI, 8'h11, "running after wrap");
    idle();
    $display("test shot stop done");
  endtask
  task automatic t_filter;
    wr(IDX_FILTER, 8'h08);
    wr(IDX_CTL_LO, 8'hE6);
    i_pin_source.pulse(3, 3);
    tick(20);
    rd(IDX_CTL_HI, 8'h00, "short edge rejected");
    i_pin_source.pulse(3, 20);
    tick(10);
    rd(IDX_CTL_HI, 8'h01, "long edge taken");
    idle();
    $display("test filter done");
  endtask
  // Main sequence
  initial
  begin
    tick(12);
    rst_i <= 1'b0;
    tick(2);
    t_reset();
    t_prescale();
    t_overflow();
    t_restart();
    t_emergency_auto();
    t_shot();
    t_filter();
    wrap_up();
  end
endmodule
`default_nettype wire
